//--- include/irec_regs.vh
// register offsets, fields, reset values and codes for the input route block
`ifndef IREC_REGS_VH
`define IREC_REGS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define IREC_FMT_OFS      8'h00
`define IREC_SMAP_OFS     8'h0E
`define IREC_DEINT_OFS    8'h0F
`define IREC_BOOST_OFS    8'h80
`define IREC_SUB_TOP      8'hFF

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define IREC_FMT_MSB      4
`define IREC_FMT_LSB      0
`define IREC_SMAP_MSB     6
`define IREC_SMAP_LSB     5
`define IREC_BOOST_BIT    7
`define IREC_DEINT_BIT    0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define IREC_FMT_RST      8'h00
`define IREC_SMAP_RST     8'h00
`define IREC_BOOST_RST    8'h00
`define IREC_DEINT_RST    8'h00

// ----------------------------------------------------------------------
// sub map codes, serial address, video modes
// ----------------------------------------------------------------------
`define IREC_MAP_USER     2'h0
`define IREC_MAP_INTR     2'h1
`define IREC_MAP_USER2    2'h2
`define IREC_DEV_ADDR_HI  6'h10
`define IREC_MODE_NONE    2'h0
`define IREC_MODE_CVBS    2'h1
`define IREC_MODE_YC      2'h2
`define IREC_MODE_COMP    2'h3

`endif

//--- hdl/irec_sync.v
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none

module irec_sync #(
  parameter W = 1
) (
  // clock and reset
  input  wire         ref_clk_i,
  input  wire         rstn_i,
  input  wire         ce_i,
  // pins and result
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // idle-high pins, so both stages reset to ones
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_ff <= {W{1'b1}};
      sync_ff <= {W{1'b1}};
    end else if (ce_i) begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule

`default_nettype wire

//--- hdl/irec_route_dec.v
// decode of the input format code into analog routing and power masks
`timescale 1ns/10ps
`default_nettype none
`include "irec_regs.vh"

module irec_route_dec #(
  parameter EIGHT_INPUT = 1
) (
  // format code
  input  wire [4:0] code_i,
  // routing result
  output reg  [1:0] mode_o,
  output reg  [7:0] luma_o,
  output reg  [7:0] chroma_o,
  output reg  [7:0] red_diff_o,
  output wire [7:0] power_o,
  output reg        reserved_o
);

  function [7:0] one_hot;
    input [2:0] idx;
    begin
      one_hot = 8'h01 << idx;
    end
  endfunction

  wire hi_ok = (EIGHT_INPUT != 0);

  always @* begin
    mode_o     = `IREC_MODE_NONE;
    luma_o     = 8'h00;
    chroma_o   = 8'h00;
    red_diff_o = 8'h00;
    reserved_o = 1'b1;
    case (code_i[4:2])
      3'h0, 3'h1: begin
        // upper four inputs exist only on the wide variant
        if (!code_i[2] || hi_ok) begin
          mode_o     = `IREC_MODE_CVBS;
          luma_o     = one_hot(code_i[2:0]);
          reserved_o = 1'b0;
        end
      end
      3'h2: begin
        if (!code_i[1] || hi_ok) begin
          mode_o     = `IREC_MODE_YC;
          luma_o     = one_hot({code_i[1:0], 1'b0});
          chroma_o   = one_hot({code_i[1:0], 1'b1});
          reserved_o = 1'b0;
        end
      end
      3'h3: begin
        if (!code_i[1] && (!code_i[0] || hi_ok)) begin
          mode_o     = `IREC_MODE_COMP;
          luma_o     = code_i[0] ? 8'h08 : 8'h01;
          chroma_o   = code_i[0] ? 8'h10 : 8'h02;
          red_diff_o = code_i[0] ? 8'h20 : 8'h04;
          reserved_o = 1'b0;
        end
      end
      default: begin
        reserved_o = 1'b1;
      end
    endcase
  end

  // unused channels stay powered down, reserved codes power none
  assign power_o = luma_o | chroma_o | red_diff_o;

endmodule

`default_nettype wire

//--- hdl/irec_top.v
// serial register bank steering analog input routing and enhancement
//
// Notes on behaviour
// - a five-bit format field in bits 4..0 of user register 0x00 sets routing and video kind.
// - codes 0 to 3 pick composite from inputs 1 to 4 on both variants.
// - codes 4 to 7 pick composite from inputs 5 to 8 on the wide variant, reserved otherwise.
// - codes 8 to 11 pick Y/C from input pairs 1/2, 3/4, 5/6, 7/8, the last two wide only.
// - code 12 picks component from inputs 1-3, code 13 from 4-6 on the wide variant only.
// - codes 14 to 31 are reserved on both variants and route nothing.
// - routing follows the code with no other mux setup, and unused channels power down.
// - contrast boost is off after reset and only the enable sequence turns it on.
// - writing 0x40 to 0x0E selects the second user map, 0x00 returns to the primary one.
// - every sub map answers at the main serial address, 0x40 or 0x42 for writes.
// - the deinterlacer is off after reset and needs no external frame memory.
// - bits 6..5 of 0x0E pick the map: 00 primary user, 01 interrupt and slicer.
// - the address-select pin sets bit 1 of the address byte, 0x40/0x42 write, 0x41/0x43 read.
`timescale 1ns/10ps
`default_nettype none
`include "irec_regs.vh"

module irec_top #(
  parameter EIGHT_INPUT = 1
) (
  // clock, reset, enable
  input  wire       ref_clk_i,
  input  wire       rstn_i,
  input  wire       ce_i,
  // serial port pins
  input  wire       scl_i,
  input  wire       sda_i,
  output wire       sda_o,
  output wire       sda_oe_o,
  input  wire       address_low_select_pin_i,
  // analog routing
  output wire [4:0] input_format_select_o,
  output reg  [1:0] video_mode_o,
  output reg  [7:0] ain_luma_sel_o,
  output reg  [7:0] ain_chroma_sel_o,
  output reg  [7:0] ain_red_diff_sel_o,
  output reg  [7:0] ain_power_up_o,
  output reg        format_reserved_o,
  // feature controls
  output wire [1:0] sub_map_select_o,
  output wire       adaptive_contrast_boost_en_o,
  output wire       deinterlace_converter_en_o
);

  // --------------------------------------------------------------------
  // states
  // --------------------------------------------------------------------
  localparam [8:0] ST_IDLE = 9'h001;
  localparam [8:0] ST_ADDR = 9'h002;
  localparam [8:0] ST_ACKA = 9'h004;
  localparam [8:0] ST_SUB  = 9'h008;
  localparam [8:0] ST_ACKS = 9'h010;
  localparam [8:0] ST_WDAT = 9'h020;
  localparam [8:0] ST_ACKW = 9'h040;
  localparam [8:0] ST_RDAT = 9'h080;
  localparam [8:0] ST_RACK = 9'h100;

  // --------------------------------------------------------------------
  // pin synchronisers and edge detection
  // --------------------------------------------------------------------
  wire [2:0] pins_s;
  reg        scl_d_ff;
  reg        sda_d_ff;

  irec_sync #(
    .W (3)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .ce_i      (ce_i),
    .async_i   ({address_low_select_pin_i, scl_i, sda_i}),
    .sync_o    (pins_s)
  );

  wire addr_pin_s = pins_s[2];
  wire scl_s  = pins_s[1];
  wire sda_s  = pins_s[0];

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else if (ce_i) begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d_ff;
  wire scl_fall = ~scl_s & scl_d_ff;
  wire bus_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire bus_stop  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // pin level moves the address bit, read/write bit is left out of the compare
  wire [6:0] dev_addr = {`IREC_DEV_ADDR_HI, addr_pin_s};

  // --------------------------------------------------------------------
  // register file state
  // --------------------------------------------------------------------
  reg [7:0] fmt_ff;
  reg [7:0] smap_ff;
  reg [7:0] boost_ff;
  reg [7:0] deint_ff;

  wire [1:0] cur_map = smap_ff[`IREC_SMAP_MSB:`IREC_SMAP_LSB];

  // map code 11 falls back to the primary user map
  function sub_ok;
    input [1:0] m;
    input [7:0] a;
    begin
      if (a == `IREC_SMAP_OFS)
        sub_ok = 1'b1;
      else if (m == `IREC_MAP_USER2)
        sub_ok = (a == `IREC_BOOST_OFS);
      else if (m == `IREC_MAP_INTR)
        sub_ok = 1'b0;
      else
        sub_ok = (a == `IREC_FMT_OFS) || (a == `IREC_DEINT_OFS);
    end
  endfunction

  // highest subaddress repeats instead of wrapping
  function [7:0] inc_sat;
    input [7:0] a;
    begin
      inc_sat = (a == `IREC_SUB_TOP) ? a : a + 8'h01;
    end
  endfunction

  // --------------------------------------------------------------------
  // serial slave state machine
  // --------------------------------------------------------------------
  reg [8:0] state_ff;
  reg [8:0] nxt_state;
  reg [3:0] bcnt_ff;
  reg [3:0] nxt_bcnt;
  reg [7:0] sh_ff;
  reg [7:0] nxt_sh;
  reg [7:0] ptr_ff;
  reg [7:0] nxt_ptr;
  reg       rw_ff;
  reg       nxt_rw;
  reg       oe_ff;
  reg       nxt_oe;
  reg       wr_stb;
  reg [7:0] rd_byte;

  always @* begin
    rd_byte = 8'h00;
    if (ptr_ff == `IREC_SMAP_OFS)
      rd_byte = smap_ff;
    else if (cur_map == `IREC_MAP_USER2) begin
      if (ptr_ff == `IREC_BOOST_OFS)
        rd_byte = boost_ff;
    end else if (cur_map != `IREC_MAP_INTR) begin
      if (ptr_ff == `IREC_FMT_OFS)
        rd_byte = fmt_ff;
      else if (ptr_ff == `IREC_DEINT_OFS)
        rd_byte = deint_ff;
    end
  end

  wire byte_done = scl_fall && (bcnt_ff == 4'h8);

  always @* begin
    nxt_state = state_ff;
    nxt_bcnt  = bcnt_ff;
    nxt_sh    = sh_ff;
    nxt_ptr   = ptr_ff;
    nxt_rw    = rw_ff;
    nxt_oe    = oe_ff;
    wr_stb    = 1'b0;
    if (bus_stop) begin
      nxt_state = ST_IDLE;
      nxt_oe    = 1'b0;
    end else if (bus_start) begin
      nxt_state = ST_ADDR;
      nxt_bcnt  = 4'h0;
      nxt_oe    = 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          nxt_oe = 1'b0;
        end
        ST_ADDR, ST_SUB, ST_WDAT: begin
          if (scl_rise) begin
            nxt_sh   = {sh_ff[6:0], sda_s};
            nxt_bcnt = bcnt_ff + 4'h1;
          end else if (byte_done) begin
            nxt_state = ST_IDLE;
            if (state_ff == ST_ADDR) begin
              // one address for every sub map
              if (sh_ff[7:1] == dev_addr) begin
                nxt_rw    = sh_ff[0];
                nxt_oe    = 1'b1;
                nxt_state = ST_ACKA;
              end
            end else if (state_ff == ST_SUB) begin
              // unknown subaddress in this map is not acknowledged
              if (sub_ok(cur_map, sh_ff)) begin
                nxt_ptr   = sh_ff;
                nxt_oe    = 1'b1;
                nxt_state = ST_ACKS;
              end
            end else if (sub_ok(cur_map, ptr_ff)) begin
              wr_stb    = 1'b1;
              nxt_oe    = 1'b1;
              nxt_state = ST_ACKW;
            end
          end
        end
        ST_ACKA: begin
          if (scl_fall) begin
            nxt_bcnt = 4'h0;
            if (rw_ff) begin
              nxt_sh    = rd_byte;
              nxt_oe    = ~rd_byte[7];
              nxt_state = ST_RDAT;
            end else begin
              nxt_oe    = 1'b0;
              nxt_state = ST_SUB;
            end
          end
        end
        ST_ACKS, ST_ACKW: begin
          if (scl_fall) begin
            nxt_oe    = 1'b0;
            nxt_bcnt  = 4'h0;
            nxt_state = ST_WDAT;
            if (state_ff == ST_ACKW)
              nxt_ptr = inc_sat(ptr_ff);
          end
        end
        ST_RDAT: begin
          if (scl_rise) begin
            nxt_bcnt = bcnt_ff + 4'h1;
          end else if (byte_done) begin
            // step early so the next byte is ready at the ack fall
            nxt_oe    = 1'b0;
            nxt_ptr   = inc_sat(ptr_ff);
            nxt_state = ST_RACK;
          end else if (scl_fall) begin
            nxt_sh = {sh_ff[6:0], 1'b0};
            nxt_oe = ~sh_ff[6];
          end
        end
        ST_RACK: begin
          if (scl_rise && sda_s) begin
            nxt_state = ST_IDLE;
          end else if (scl_fall) begin
            nxt_bcnt  = 4'h0;
            nxt_sh    = rd_byte;
            nxt_oe    = ~rd_byte[7];
            nxt_state = ST_RDAT;
          end
        end
        default: begin
          nxt_state = ST_IDLE;
          nxt_oe    = 1'b0;
        end
      endcase
    end
  end

  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= ST_IDLE;
      bcnt_ff  <= 4'h0;
      sh_ff    <= 8'h00;
      ptr_ff   <= 8'h00;
      rw_ff    <= 1'b0;
      oe_ff    <= 1'b0;
    end else if (ce_i) begin
      state_ff <= nxt_state;
      bcnt_ff  <= nxt_bcnt;
      sh_ff    <= nxt_sh;
      ptr_ff   <= nxt_ptr;
      rw_ff    <= nxt_rw;
      oe_ff    <= nxt_oe;
    end
  end

  // open drain: only ever pull low
  assign sda_o    = 1'b0;
  assign sda_oe_o = oe_ff;

  // --------------------------------------------------------------------
  // register writes
  // --------------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fmt_ff   <= `IREC_FMT_RST;
      smap_ff  <= `IREC_SMAP_RST;
      boost_ff <= `IREC_BOOST_RST;
      deint_ff <= `IREC_DEINT_RST;
    end else if (ce_i && wr_stb) begin
      if (ptr_ff == `IREC_SMAP_OFS)
        smap_ff <= sh_ff;
      else if (cur_map == `IREC_MAP_USER2)
        boost_ff <= sh_ff;
      else if (ptr_ff == `IREC_FMT_OFS)
        fmt_ff <= sh_ff;
      else
        deint_ff <= sh_ff;
    end
  end

  assign input_format_select_o =
    fmt_ff[`IREC_FMT_MSB:`IREC_FMT_LSB];
  assign sub_map_select_o      = cur_map;
  assign adaptive_contrast_boost_en_o = boost_ff[`IREC_BOOST_BIT];
  // line doubling works from line stores only, no frame memory port
  assign deinterlace_converter_en_o = deint_ff[`IREC_DEINT_BIT];

  // --------------------------------------------------------------------
  // analog routing
  // --------------------------------------------------------------------
  wire [1:0] dec_mode;
  wire [7:0] dec_luma;
  wire [7:0] dec_chroma;
  wire [7:0] dec_red;
  wire [7:0] dec_power;
  wire       dec_rsvd;

  irec_route_dec #(
    .EIGHT_INPUT (EIGHT_INPUT)
  ) u_route (
    .code_i     (fmt_ff[`IREC_FMT_MSB:`IREC_FMT_LSB]),
    .mode_o     (dec_mode),
    .luma_o     (dec_luma),
    .chroma_o   (dec_chroma),
    .red_diff_o (dec_red),
    .power_o    (dec_power),
    .reserved_o (dec_rsvd)
  );

  // registered so the analog switches never see decode glitches
  always @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      video_mode_o       <= `IREC_MODE_NONE;
      ain_luma_sel_o     <= 8'h00;
      ain_chroma_sel_o   <= 8'h00;
      ain_red_diff_sel_o <= 8'h00;
      ain_power_up_o     <= 8'h00;
      format_reserved_o  <= 1'b0;
    end else if (ce_i) begin
      video_mode_o       <= dec_mode;
      ain_luma_sel_o     <= dec_luma;
      ain_chroma_sel_o   <= dec_chroma;
      ain_red_diff_sel_o <= dec_red;
      ain_power_up_o     <= dec_power;
      format_reserved_o  <= dec_rsvd;
    end
  end

endmodule

`default_nettype wire

//--- test/irec_top_sva.sv
// port checks for the input route and enhance block
`timescale 1ns/10ps
`default_nettype none

module irec_top_sva #(
  parameter EIGHT_INPUT = 1
) (
  // clock and reset
  input wire logic       ref_clk_i,
  input wire logic       rstn_i,
  // serial pins
  input wire logic       scl_i,
  input wire logic       sda_oe_o,
  // routing and controls
  input wire logic [4:0] input_format_select_o,
  input wire logic [1:0] video_mode_o,
  input wire logic [7:0] ain_luma_sel_o,
  input wire logic [7:0] ain_chroma_sel_o,
  input wire logic [7:0] ain_red_diff_sel_o,
  input wire logic [7:0] ain_power_up_o,
  input wire logic       format_reserved_o,
  input wire logic [1:0] sub_map_select_o,
  input wire logic       adaptive_contrast_boost_en_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_drive_start;
    $rose(sda_oe_o);
  endsequence
  sequence s_scl_high;
    scl_i [*2];
  endsequence
  // ----------------------------------------
  // routing
  // ----------------------------------------
  AST_POWER_OR: assert property (
    ain_power_up_o ==
    (ain_luma_sel_o | ain_chroma_sel_o | ain_red_diff_sel_o))
    else $error("power mask differs from selects");
  AST_CVBS_ONE: assert property (
    video_mode_o == 2'h1 |-> $onehot(ain_luma_sel_o) &&
    ain_chroma_sel_o == 8'h00 && ain_red_diff_sel_o == 8'h00)
    else $error("composite select not single");
  AST_YC_PAIR: assert property (
    video_mode_o == 2'h2 |-> $onehot(ain_luma_sel_o) &&
    ain_chroma_sel_o == ain_luma_sel_o << 1 && ain_red_diff_sel_o == 8'h00)
    else $error("luma chroma pair wrong");
  AST_COMP_TRIO: assert property (
    video_mode_o == 2'h3 |-> ain_luma_sel_o inside {8'h01, 8'h08} &&
    ain_chroma_sel_o == ain_luma_sel_o << 1 &&
    ain_red_diff_sel_o == ain_luma_sel_o << 2)
    else $error("component trio wrong");
  AST_LOW_CODE: assert property (
    input_format_select_o < 5'h04 |=> video_mode_o == 2'h1 &&
    ain_luma_sel_o == 8'h01 << $past(input_format_select_o))
    else $error("low code routing wrong");
  AST_RSV_CODE: assert property (
    input_format_select_o >= 5'h0E |=> format_reserved_o &&
    video_mode_o == 2'h0 && ain_power_up_o == 8'h00)
    else $error("reserved code routes something");
  AST_FOUR_IN: assert property (
    EIGHT_INPUT == 0 |-> ain_power_up_o[7:4] == 4'h0)
    else $error("narrow part uses high inputs");
  // ----------------------------------------
  // sub map and serial port
  // ----------------------------------------
  AST_BOOST_MAP: assert property (
    $changed(adaptive_contrast_boost_en_o) |-> sub_map_select_o == 2'h2)
    else $error("boost changed outside second map");
  AST_ACK_LOW: assert property (
    s_drive_start |-> !scl_i)
    else $error("sda driven while scl high");
  AST_OE_STEADY: assert property (
    s_scl_high |-> $stable(sda_oe_o))
    else $error("sda drive moved during scl high");
endmodule
`default_nettype wire

//--- test/irec_host.sv
// serial host model: drives scl, pulls sda low
`timescale 1ns/10ps
`default_nettype none

module irec_host (
  // clock and wire level
  input  wire logic ref_clk_i,
  input  wire logic sda_i,
  // driven pins
  output var logic  scl_o,
  output var logic  sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // ----------------------------------------
  // 8 low, 8 high cycles: well past pin sync delay
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic bit_x(input logic d, output logic q);
    sda_low_o <= ~d;
    tick(4);
    scl_o <= 1'b1;
    tick(4);
    q = sda_i;
    tick(4);
    scl_o <= 1'b0;
    tick(4);
  endtask
  task automatic start();
    sda_low_o <= 1'b0;
    tick(4);
    scl_o <= 1'b1;
    tick(8);
    sda_low_o <= 1'b1;
    tick(8);
    scl_o <= 1'b0;
    tick(4);
  endtask
  task automatic stop();
    sda_low_o <= 1'b1;
    tick(4);
    scl_o <= 1'b1;
    tick(8);
    sda_low_o <= 1'b0;
    tick(8);
  endtask
  task automatic put(input logic [7:0] d, output logic nack);
    logic q;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q);
    end
    bit_x(1'b1, nack);
  endtask
  // always ends a read with no acknowledge
  task automatic get(output logic [7:0] d);
    logic q;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(1'b1, q);
  endtask
endmodule
`default_nettype wire

//--- test/input_route_and_enhance_ctrl_test.sv
// bench for the input route and enhance block, two parts on one bus
`timescale 1ns/10ps
`default_nettype none
`include "irec_regs.vh"

module input_route_and_enhance_ctrl_test;
  logic       ref_clk_i;
  logic       rstn_i = 1'b0;
  logic       ce_i = 1'b1;
  wire        scl_w;
  wire        sda_w;
  wire        host_low;
  wire        oe [0:1];
  wire [4:0]  fmt [0:1];
  wire [34:0] rt [0:1];
  wire [1:0]  smap [0:1];
  wire        boost [0:1];
  wire        deint [0:1];
  int         num_errors = 0;
  int         num_checks = 0;
  int         cycles = 0;
  // open drain with pull-up: any low pull wins
  assign sda_w = !(oe[0] | oe[1] | host_low);
  irec_host host (.ref_clk_i(ref_clk_i), .sda_i(sda_w),
    .scl_o(scl_w), .sda_low_o(host_low));
  // part 0: eight inputs at 0x40, part 1: four inputs at 0x42
  for (genvar g = 0; g < 2; g++) begin : u_part
    irec_top #(.EIGHT_INPUT(1 - g)) dut (
      .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
      .scl_i(scl_w), .sda_i(sda_w), .sda_o(), .sda_oe_o(oe[g]),
      .address_low_select_pin_i(g == 1),
      .input_format_select_o(fmt[g]), .video_mode_o(rt[g][34:33]),
      .ain_luma_sel_o(rt[g][32:25]), .ain_chroma_sel_o(rt[g][24:17]),
      .ain_red_diff_sel_o(rt[g][16:9]), .ain_power_up_o(rt[g][8:1]),
      .format_reserved_o(rt[g][0]), .sub_map_select_o(smap[g]),
      .adaptive_contrast_boost_en_o(boost[g]),
      .deinterlace_converter_en_o(deint[g]));
  end
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      num_errors++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, exp, input string what);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s", $time, what);
    end
  endtask
  function automatic logic [34:0] exp_rt(input logic [4:0] c, logic w);
    logic [7:0] y;
    logic [7:0] cb;
    logic [7:0] cr;
    logic [1:0] m;
    {m, y, cb, cr} = '0;
    if (c < 5'h08 && (c < 5'h04 || w)) begin
      m = 2'h1;
      y = 8'h01 << c[2:0];
    end else if (c < 5'h0C && c >= 5'h08 && (c < 5'h0A || w)) begin
      m = 2'h2;
      y = 8'h01 << {c[1:0], 1'b0};
      cb = y << 1;
    end else if (c == 5'h0C || (c == 5'h0D && w)) begin
      m = 2'h3;
      y = c[0] ? 8'h08 : 8'h01;
      cb = y << 1;
      cr = y << 2;
    end
    return {m, y, cb, cr, y | cb | cr, m == 2'h0};
  endfunction
  // nk bits: address, subaddress, data; 1 = no acknowledge
  task automatic wr(input logic [7:0] dev, sub, dat, output logic [2:0] nk);
    host.start();
    host.put(dev, nk[2]);
    host.put(sub, nk[1]);
    host.put(dat, nk[0]);
    host.stop();
  endtask
  task automatic rd(input logic [7:0] dev, sub, output logic [7:0] q,
                    output logic [2:0] nk);
    host.start();
    host.put(dev, nk[2]);
    host.put(sub, nk[1]);
    host.start();
    host.put(dev | 8'h01, nk[0]);
    host.get(q);
    host.stop();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(boost[0], 1'b0, "boost on after reset");
    chk(deint[0], 1'b0, "deint on after reset");
    chk(smap[0], `IREC_MAP_USER, "map after reset");
    chk(rt[0], exp_rt(5'h00, 1'b1), "route after reset");
    $display("test reset done");
  endtask
  task automatic t_formats();
    logic [2:0] nk;
    logic [4:0] c;
    for (int i = 0; i < 32; i++) begin
      c = i[4:0];
      wr(8'h40, `IREC_FMT_OFS, {3'h0, c}, nk);
      chk(nk, 3'h0, "wide part refused");
      wr(8'h42, `IREC_FMT_OFS, {3'h0, c}, nk);
      chk(nk, 3'h0, "narrow part refused");
      chk(fmt[0], c, "format field");
      chk(rt[0], exp_rt(c, 1'b1), "wide route");
      chk(rt[1], exp_rt(c, 1'b0), "narrow route");
    end
    $display("test formats done");
  endtask
  task automatic t_boost();
    logic [2:0] nk;
    logic [7:0] q;
    wr(8'h40, `IREC_BOOST_OFS, 8'h80, nk);
    chk({nk, boost[0]}, 4'h6, "boost set from primary map");
    wr(8'h40, `IREC_SMAP_OFS, 8'h40, nk);
    chk(smap[0], `IREC_MAP_USER2, "second map not entered");
    wr(8'h40, `IREC_BOOST_OFS, 8'h80, nk);
    chk(boost[0], 1'b1, "boost not on");
    rd(8'h40, `IREC_BOOST_OFS, q, nk);
    chk({nk, q}, 11'h080, "boost readback");
    wr(8'h40, `IREC_FMT_OFS, 8'h05, nk);
    chk(nk, 3'h3, "format taken in second map");
    wr(8'h40, `IREC_SMAP_OFS, 8'h00, nk);
    chk({smap[0], boost[0]}, 3'h1, "primary map return");
    wr(8'h40, `IREC_SMAP_OFS, 8'h40, nk);
    wr(8'h40, `IREC_BOOST_OFS, 8'h00, nk);
    wr(8'h40, `IREC_SMAP_OFS, 8'h00, nk);
    chk({smap[0], boost[0]}, 3'h0, "boost not off");
    $display("test boost done");
  endtask
  task automatic t_maps_deint();
    logic [2:0] nk;
    logic [7:0] q;
    wr(8'h40, `IREC_SMAP_OFS, 8'h20, nk);
    chk(smap[0], `IREC_MAP_INTR, "interrupt map not entered");
    wr(8'h40, `IREC_DEINT_OFS, 8'h01, nk);
    chk({nk, deint[0]}, 4'h6, "user reg open in intr map");
    wr(8'h40, `IREC_SMAP_OFS, 8'h00, nk);
    wr(8'h40, `IREC_DEINT_OFS, 8'h01, nk);
    chk(deint[0], 1'b1, "deint not on");
    rd(8'h40, `IREC_DEINT_OFS, q, nk);
    chk({nk, q}, 11'h001, "deint readback");
    wr(8'h40, `IREC_DEINT_OFS, 8'h00, nk);
    chk(deint[0], 1'b0, "deint not off");
    $display("test maps done");
  endtask
  task automatic t_addr();
    logic [2:0] nk;
    logic [7:0] q;
    wr(8'h44, `IREC_FMT_OFS, 8'h03, nk);
    chk({nk, fmt[0], fmt[1]}, 13'h1FFF, "foreign address taken");
    rd(8'h42, `IREC_FMT_OFS, q, nk);
    chk({nk, q}, 11'h01F, "read at odd address");
    $display("test address done");
  endtask
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    t_reset();
    t_formats();
    t_boost();
    t_maps_deint();
    t_addr();
    give_verdict();
  end
endmodule

bind irec_top irec_top_sva #(.EIGHT_INPUT(EIGHT_INPUT)) sva (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .scl_i(scl_i),
  .sda_oe_o(sda_oe_o), .input_format_select_o(input_format_select_o),
  .video_mode_o(video_mode_o), .ain_luma_sel_o(ain_luma_sel_o),
  .ain_chroma_sel_o(ain_chroma_sel_o),
  .ain_red_diff_sel_o(ain_red_diff_sel_o),
  .ain_power_up_o(ain_power_up_o), .format_reserved_o(format_reserved_o),
  .sub_map_select_o(sub_map_select_o),
  .adaptive_contrast_boost_en_o(adaptive_contrast_boost_en_o));
`default_nettype wire
